//--- common/sdt_params.svh
/*
  Constants of the shading data transfer command block: command
  identifiers, transfer mode bytes, payload limits and pixel geometry.
  Assumes it is included by bare name once per compilation unit.
*/
`ifndef SDT_PARAMS_SVH
`define SDT_PARAMS_SVH

// Command identifiers
`define SDT_CMD_XFER 8'h68
`define SDT_CMD_DATA 8'h69

// Transfer mode bytes
`define SDT_MODE_CLOSE 8'h00
`define SDT_MODE_OPEN_NV 8'h50
`define SDT_MODE_OPEN_V 8'h51
`define SDT_MODE_COPY 8'h80

// Payload lengths
`define SDT_XFER_LEN 6'h01
`define SDT_MAX_LEN 6'h3A

// Pixel geometry: 2048 multipliers per bank, two banks
`define SDT_PIX_W 11
`define SDT_ADDR_W 12
`define SDT_LAST_PIX 11'h7FF
`define SDT_BANK_NV 1'h1
`define SDT_BANK_V 1'h0

`endif

//--- common/sdt_pkg.sv
/*
  Types shared by the shading data transfer command block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sdt_pkg;

  // Command interpreter states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MODE_RD,
    ST_MODE_WR,
    ST_DATA_WR,
    ST_DATA_RD,
    ST_COPY
  } sdt_state_t;

endpackage : sdt_pkg

//--- hw/sdt_mem.sv
/*
  Two-bank multiplier store: one write port, one read port whose data
  come out of a register one cycle after the read strobe.
  Assumes a single clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "sdt_params.svh"

module sdt_mem (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [`SDT_ADDR_W-1:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic rd_en_in,
  input wire logic [`SDT_ADDR_W-1:0] rd_addr_in,
  output logic [7:0] rd_data_out
);

  logic [7:0] mem_q [0:(1<<`SDT_ADDR_W)-1];
  logic [7:0] rd_d;

  // Array has no reset; contents are undefined until written
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Read data held until the next read strobe
  always_comb begin
    rd_d = rd_data_out;
    if (rd_en_in) begin
      rd_d = mem_q[rd_addr_in];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= rd_d;
    end
  end

endmodule : sdt_mem

//--- hw/sdt_cmd.sv
/*
  Interpreter for the shading transfer-control and shading data
  commands, with the multiplier store behind it.
  Assumes the command processor has parsed each frame into a header
  strobe and payload byte strobes, and presents no header while
  busy_out is high. Responses leave as a header strobe then bytes.
*/
`timescale 1ns/10ps
`include "sdt_params.svh"

module sdt_cmd
  import sdt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic hdr_valid_in,
  input wire logic [7:0] hdr_cmd_in,
  input wire logic hdr_rd_in,
  input wire logic [5:0] hdr_len_in,
  input wire logic [`SDT_PIX_W-1:0] sect_base_in,
  input wire logic data_valid_in,
  input wire logic [7:0] data_in,
  output logic busy_out,
  output logic [7:0] store_mode_out,
  output logic wr_reject_out,
  output logic rsp_hdr_valid_out,
  output logic [7:0] rsp_cmd_out,
  output logic rsp_rd_out,
  output logic [5:0] rsp_len_out,
  output logic rsp_data_valid_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_last_out
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  sdt_state_t state_q, state_d;
  logic [7:0] mode_q, mode_d;
  logic [`SDT_PIX_W-1:0] ptr_q, ptr_d;
  logic [5:0] cnt_q, cnt_d;
  logic pend_q, pend_d;
  logic pend_cpy_q, pend_cpy_d;
  logic pend_last_q, pend_last_d;
  logic [`SDT_PIX_W-1:0] pend_pix_q, pend_pix_d;
  logic busy_d, reject_d;
  logic rsp_hdr_d, rsp_dv_d, rsp_last_d;
  logic [7:0] rsp_cmd_d, rsp_data_d;
  logic [5:0] rsp_len_d;
  logic mem_we, mem_re;
  logic [`SDT_ADDR_W-1:0] mem_wa, mem_ra;
  logic [7:0] mem_wd, mem_rdata;
  logic len_ok, is_open;

  // Bank bit on top of the pixel index
  function automatic logic [`SDT_ADDR_W-1:0] pix_addr(
    input logic bank,
    input logic [`SDT_PIX_W-1:0] pix
  );
    pix_addr = {bank, pix};
  endfunction : pix_addr

  ////////////////////////////////////////////////////////////////////////
  // Multiplier store

  sdt_mem u_mem (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .wr_en_in(mem_we),
    .wr_addr_in(mem_wa),
    .wr_data_in(mem_wd),
    .rd_en_in(mem_re),
    .rd_addr_in(mem_ra),
    .rd_data_out(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    len_ok = (hdr_len_in != 6'h00) && (hdr_len_in <= `SDT_MAX_LEN);
    is_open = (mode_q == `SDT_MODE_OPEN_NV) ||
              (mode_q == `SDT_MODE_OPEN_V);
    state_d = state_q;
    mode_d = mode_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    pend_d = 1'b0;
    pend_cpy_d = 1'b0;
    pend_last_d = 1'b0;
    pend_pix_d = pend_pix_q;
    reject_d = 1'b0;
    rsp_hdr_d = 1'b0;
    rsp_cmd_d = rsp_cmd_out;
    rsp_len_d = rsp_len_out;
    rsp_dv_d = 1'b0;
    rsp_data_d = rsp_data_out;
    rsp_last_d = 1'b0;
    mem_we = 1'b0;
    mem_wa = pix_addr(`SDT_BANK_V, pend_pix_q);
    mem_wd = mem_rdata;
    mem_re = 1'b0;
    mem_ra = pix_addr(`SDT_BANK_V, ptr_q);

    // Read data returning from the store: to the host or to the copy
    if (pend_q && pend_cpy_q) begin
      mem_we = 1'b1;
    end else if (pend_q) begin
      rsp_dv_d = 1'b1;
      rsp_data_d = mem_rdata;
      rsp_last_d = pend_last_q;
    end

    case (state_q)
      ST_IDLE: begin
        if (hdr_valid_in && hdr_cmd_in == `SDT_CMD_XFER &&
            hdr_len_in == `SDT_XFER_LEN) begin
          if (hdr_rd_in) begin
            rsp_hdr_d = 1'b1;
            rsp_cmd_d = hdr_cmd_in;
            rsp_len_d = hdr_len_in;
            state_d = ST_MODE_RD;
          end else begin
            state_d = ST_MODE_WR;
          end
        end else if (hdr_valid_in && hdr_cmd_in == `SDT_CMD_DATA &&
                     len_ok) begin
          ptr_d = sect_base_in;
          cnt_d = hdr_len_in;
          if (hdr_rd_in) begin
            rsp_hdr_d = 1'b1;
            rsp_cmd_d = hdr_cmd_in;
            rsp_len_d = hdr_len_in;
            state_d = ST_DATA_RD;
          end else if (is_open) begin
            state_d = ST_DATA_WR;
          end else begin
            reject_d = 1'b1;
          end
        end
      end
      ST_MODE_RD: begin
        rsp_dv_d = 1'b1;
        rsp_data_d = mode_q;
        rsp_last_d = 1'b1;
        state_d = ST_IDLE;
      end
      ST_MODE_WR: begin
        if (data_valid_in) begin
          state_d = ST_IDLE;
          case (data_in)
            `SDT_MODE_CLOSE: mode_d = data_in;
            `SDT_MODE_OPEN_NV: mode_d = data_in;
            `SDT_MODE_OPEN_V: mode_d = data_in;
            `SDT_MODE_COPY: begin
              mode_d = `SDT_MODE_CLOSE;
              ptr_d = '0;
              state_d = ST_COPY;
            end
            default: mode_d = mode_q;
          endcase
        end
      end
      ST_DATA_WR: begin
        if (data_valid_in) begin
          mem_we = 1'b1;
          mem_wa = pix_addr(mode_q == `SDT_MODE_OPEN_NV, ptr_q);
          mem_wd = data_in;
          ptr_d = ptr_q + 1'b1;
          cnt_d = cnt_q - 1'b1;
          if (cnt_q == 6'h01) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_DATA_RD: begin
        mem_re = 1'b1;
        pend_d = 1'b1;
        pend_last_d = (cnt_q == 6'h01);
        ptr_d = ptr_q + 1'b1;
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 6'h01) begin
          state_d = ST_IDLE;
        end
      end
      ST_COPY: begin
        mem_re = 1'b1;
        mem_ra = pix_addr(`SDT_BANK_NV, ptr_q);
        pend_d = 1'b1;
        pend_cpy_d = 1'b1;
        pend_pix_d = ptr_q;
        ptr_d = ptr_q + 1'b1;
        if (ptr_q == `SDT_LAST_PIX) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Busy also covers the last pending read, so no header overlaps it
    busy_d = (state_d != ST_IDLE) || pend_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      mode_q <= `SDT_MODE_CLOSE;
      ptr_q <= '0;
      cnt_q <= 6'h00;
      pend_q <= 1'b0;
      pend_cpy_q <= 1'b0;
      pend_last_q <= 1'b0;
      pend_pix_q <= '0;
      busy_out <= 1'b0;
      wr_reject_out <= 1'b0;
      rsp_hdr_valid_out <= 1'b0;
      rsp_cmd_out <= 8'h00;
      rsp_rd_out <= 1'b0;
      rsp_len_out <= 6'h00;
      rsp_data_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      rsp_last_out <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      pend_cpy_q <= pend_cpy_d;
      pend_last_q <= pend_last_d;
      pend_pix_q <= pend_pix_d;
      busy_out <= busy_d;
      wr_reject_out <= reject_d;
      rsp_hdr_valid_out <= rsp_hdr_d;
      rsp_cmd_out <= rsp_cmd_d;
      rsp_rd_out <= 1'b0;
      rsp_len_out <= rsp_len_d;
      rsp_data_valid_out <= rsp_dv_d;
      rsp_data_out <= rsp_data_d;
      rsp_last_out <= rsp_last_d;
    end
  end

  // Store mode is the registered mode byte itself
  assign store_mode_out = mode_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_mode_wr(logic [7:0] val);
    state_q == ST_MODE_WR && data_valid_in && data_in == val;
  endsequence

  sequence s_data_read_req;
    state_q == ST_IDLE && hdr_valid_in && hdr_rd_in &&
    hdr_cmd_in == `SDT_CMD_DATA && len_ok;
  endsequence

  property p_mode_read_echo;
    rsp_hdr_valid_out && rsp_cmd_out == `SDT_CMD_XFER |=>
      rsp_data_valid_out && rsp_last_out && rsp_data_out == mode_q;
  endproperty
  a_mode_read_echo: assert property (p_mode_read_echo)
    else $error("mode read did not return the mode byte");

  property p_open_nv;
    s_mode_wr(`SDT_MODE_OPEN_NV) |=> store_mode_out == `SDT_MODE_OPEN_NV
      && state_q == ST_IDLE;
  endproperty
  a_open_nv: assert property (p_open_nv)
    else $error("open for non-volatile upload not taken");

  property p_open_v;
    s_mode_wr(`SDT_MODE_OPEN_V) |=> store_mode_out == `SDT_MODE_OPEN_V;
  endproperty
  a_open_v: assert property (p_open_v)
    else $error("open for volatile upload not taken");

  property p_copy;
    s_mode_wr(`SDT_MODE_COPY) |=> state_q == ST_COPY && busy_out ##1
      pend_q && pend_cpy_q ##0 (mem_we && mem_wa[`SDT_PIX_W] == 1'b0);
  endproperty
  a_copy: assert property (p_copy)
    else $error("copy did not write the volatile bank");

  property p_closed_reject;
    state_q == ST_IDLE && hdr_valid_in && !hdr_rd_in && !is_open &&
    hdr_cmd_in == `SDT_CMD_DATA && len_ok |=>
      wr_reject_out && state_q == ST_IDLE;
  endproperty
  a_closed_reject: assert property (p_closed_reject)
    else $error("data write taken while storage closed");

  property p_write_bank;
    state_q == ST_DATA_WR && data_valid_in |-> mem_we &&
      mem_wa[`SDT_PIX_W] == (store_mode_out == `SDT_MODE_OPEN_NV);
  endproperty
  a_write_bank: assert property (p_write_bank)
    else $error("data write sent to the wrong bank");

  property p_read_one;
    s_data_read_req ##0 hdr_len_in == 6'h01 |=> rsp_hdr_valid_out ##2
      rsp_data_valid_out && rsp_last_out;
  endproperty
  a_read_one: assert property (p_read_one)
    else $error("single byte read not answered with one last byte");

  property p_read_echo;
    s_data_read_req |=> rsp_hdr_valid_out && !rsp_rd_out &&
      rsp_len_out == $past(hdr_len_in) && rsp_cmd_out == `SDT_CMD_DATA;
  endproperty
  a_read_echo: assert property (p_read_echo)
    else $error("read response header does not echo the request");

  property p_write_silent;
    state_q == ST_IDLE && hdr_valid_in && !hdr_rd_in |=>
      !rsp_hdr_valid_out [*2];
  endproperty
  a_write_silent: assert property (p_write_silent)
    else $error("write produced a response");

endmodule : sdt_cmd

//--- verification/sdt_host.sv
/*
  Host controller model: sends parsed command headers and payloads.
  Assumes one clock and that each call starts just after a rising edge.
*/
`timescale 1ns/10ps

module sdt_host (
  input wire logic clk_in,
  input wire logic busy_in,
  output logic hdr_valid_out,
  output logic [7:0] hdr_cmd_out,
  output logic hdr_rd_out,
  output logic [5:0] hdr_len_out,
  output logic [10:0] sect_base_out,
  output logic data_valid_out,
  output logic [7:0] data_out
);
  // Quiet link at time zero
  initial begin
    hdr_valid_out = 1'h0;
    hdr_cmd_out = 8'h00;
    hdr_rd_out = 1'h0;
    hdr_len_out = 6'h00;
    sect_base_out = 11'h000;
    data_valid_out = 1'h0;
    data_out = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////
  // One whole command; released lines show inverted values so that
  // stale data is never mistaken for a live byte
  task automatic send(input logic [7:0] cmd, input logic rd,
    input logic [5:0] len, input logic [10:0] base,
    input logic [7:0] pl [64]);
    int i;
    int n;
    hdr_valid_out = 1'h1;
    hdr_cmd_out = cmd;
    hdr_rd_out = rd;
    hdr_len_out = len;
    sect_base_out = base;
    @(posedge clk_in);
    #1;
    hdr_valid_out = 1'h0;
    hdr_cmd_out = ~cmd;
    hdr_rd_out = ~rd;
    hdr_len_out = ~len;
    sect_base_out = ~base;
    // Payload bytes back to back, first byte first
    for (i = 0; i < int'(len) && !rd; i++) begin
      data_valid_out = 1'h1;
      data_out = pl[i];
      @(posedge clk_in);
      #1;
    end
    data_valid_out = 1'h0;
    data_out = ~data_out;
    // One command at a time, copy included
    for (n = 0; n < 3000 && busy_in !== 1'h0; n++) begin
      @(posedge clk_in);
      #1;
    end
  endtask : send
endmodule : sdt_host

//--- verification/sdt_cmd_tb_top.sv
/*
  Self-checking bench of the shading command interpreter.
  Assumes the host model sdt_host and a fixed xorshift seed of 4.
*/
`timescale 1ns/10ps
`include "sdt_params.svh"

module sdt_cmd_tb_top;
  logic clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic hdr_valid, hdr_rd, data_valid, busy, wr_reject;
  logic rsp_hdr_valid, rsp_rd, rsp_data_valid, rsp_last;
  logic [7:0] hdr_cmd, data, store_mode, rsp_cmd, rsp_data;
  logic [5:0] hdr_len, rsp_len;
  logic [10:0] sect_base;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n_got = 0;
  int n_rej = 0;
  int last_idx = -1;
  int n_hdr = 0;
  int n_busy = 0;
  logic [7:0] got [256];
  logic [7:0] exp_v [2048];
  logic [7:0] exp_nv [2048];
  logic [7:0] pl [64];
  logic [7:0] mode_e = 8'h00;
  logic [31:0] seed = 32'h4;
  logic [7:0] mt [4] = '{8'h51, 8'h33, 8'h50, 8'h00};

  sdt_cmd uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .hdr_valid_in(hdr_valid), .hdr_cmd_in(hdr_cmd), .hdr_rd_in(hdr_rd),
    .hdr_len_in(hdr_len), .sect_base_in(sect_base),
    .data_valid_in(data_valid), .data_in(data), .busy_out(busy),
    .store_mode_out(store_mode), .wr_reject_out(wr_reject),
    .rsp_hdr_valid_out(rsp_hdr_valid), .rsp_cmd_out(rsp_cmd),
    .rsp_rd_out(rsp_rd), .rsp_len_out(rsp_len),
    .rsp_data_valid_out(rsp_data_valid), .rsp_data_out(rsp_data),
    .rsp_last_out(rsp_last));

  sdt_host host (.clk_in(clk_in), .busy_in(busy),
    .hdr_valid_out(hdr_valid), .hdr_cmd_out(hdr_cmd),
    .hdr_rd_out(hdr_rd), .hdr_len_out(hdr_len),
    .sect_base_out(sect_base), .data_valid_out(data_valid),
    .data_out(data));

  // 250 MHz clock
  initial begin
    forever #2 clk_in = ~clk_in;
  end

  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Section pixels wrap at the 11-bit index
  function automatic logic [10:0] pix(input logic [10:0] b, input int k);
    return b + 11'(k);
  endfunction : pix

  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  // Event and cycle counts
  task automatic chk_cnt(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t: count %0d want %0d", $time, g, e);
    end
  endtask : chk_cnt

  // Response capture; also the hang limit
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (rsp_data_valid === 1'h1) begin
      got[n_got % 256] <= rsp_data;
      n_got <= n_got + 1;
    end
    if (rsp_last === 1'h1) last_idx <= n_got;
    if (wr_reject === 1'h1) n_rej <= n_rej + 1;
    if (rsp_hdr_valid === 1'h1) n_hdr <= n_hdr + 1;
    if (busy === 1'h1) n_busy <= n_busy + 1;
    if (cyc == 6000) begin
      n_fail++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////
  task automatic setmode(input logic [7:0] m);
    pl[0] = m;
    host.send(`SDT_CMD_XFER, 1'h0, 6'h01, 11'h000, pl);
  endtask : setmode

  // Random payload; the model follows the open bank
  task automatic wr(input logic [10:0] b, input int n);
    int k;
    int h;
    h = n_hdr;
    for (k = 0; k < n; k++) begin
      seed = xs(seed);
      pl[k] = seed[7:0];
      if (mode_e == `SDT_MODE_OPEN_V) exp_v[pix(b, k)] = pl[k];
      if (mode_e == `SDT_MODE_OPEN_NV) exp_nv[pix(b, k)] = pl[k];
    end
    host.send(`SDT_CMD_DATA, 1'h0, 6'(n), b, pl);
    chk_cnt(32'(n_hdr - h), 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] c, input logic [10:0] b,
    input int n, output int s);
    int h;
    s = n_got;
    h = n_hdr;
    host.send(c, 1'h1, 6'(n), b, pl);
    @(posedge clk_in);
    #1;
    chk(rsp_cmd, c);
    chk({7'h00, rsp_rd}, 8'h00);
    chk({2'h0, rsp_len}, 8'(n));
    chk(8'(n_got - s), 8'(n));
    chk_cnt(32'(n_hdr - h), 32'h1);
    chk(8'(last_idx - s), 8'(n - 1));
  endtask : rd

  task automatic rdchk(input logic [10:0] b, input int n);
    int s;
    int k;
    rd(`SDT_CMD_DATA, b, n, s);
    for (k = 0; k < n; k++) begin
      chk(got[(s + k) % 256], exp_v[pix(b, k)]);
    end
  endtask : rdchk

  // Main sequence
  initial begin
    int i;
    int s;
    repeat (12) @(posedge clk_in);
    #1;
    rst_n_in = 1'h1;
    chk(store_mode, 8'h00);
    // Out of reset nothing is busy and no response is pending
    chk({busy, wr_reject, rsp_hdr_valid, rsp_data_valid, rsp_last,
      rsp_rd, 2'h0}, 8'h00);
    wr(11'h010, 3);
    @(posedge clk_in);
    #1;
    chk(8'(n_rej), 8'h01);
    $display("test closed_write done");
    for (i = 0; i < 4; i++) begin
      setmode(mt[i]);
      if (mt[i] != 8'h33) mode_e = mt[i];
      chk(store_mode, mode_e);
      rd(`SDT_CMD_XFER, 11'h000, 1, s);
      chk(got[s % 256], mode_e);
    end
    $display("test modes done");
    // Bad lengths and a foreign id are dropped with no response
    s = n_hdr;
    host.send(`SDT_CMD_DATA, 1'h1, 6'h00, 11'h000, pl);
    @(posedge clk_in);
    #1;
    host.send(`SDT_CMD_DATA, 1'h1, `SDT_MAX_LEN + 6'h01, 11'h000, pl);
    @(posedge clk_in);
    #1;
    host.send(8'h6A, 1'h1, 6'h01, 11'h000, pl);
    @(posedge clk_in);
    #1;
    chk_cnt(32'(n_hdr - s), 32'h0);
    $display("test bad_header done");
    setmode(`SDT_MODE_OPEN_V);
    mode_e = `SDT_MODE_OPEN_V;
    wr(11'h7E0, 58);
    wr(11'h100, 1);
    rdchk(11'h7E0, 58);
    rdchk(11'h100, 1);
    $display("test volatile done");
    setmode(`SDT_MODE_OPEN_NV);
    mode_e = `SDT_MODE_OPEN_NV;
    wr(11'h7E0, 20);
    rdchk(11'h7E0, 20);
    setmode(`SDT_MODE_CLOSE);
    mode_e = `SDT_MODE_CLOSE;
    s = n_busy;
    setmode(`SDT_MODE_COPY);
    // Mode byte, every pixel read, then the last write-back
    chk_cnt(32'(n_busy - s), 32'(`SDT_LAST_PIX) + 32'h3);
    chk({7'h00, busy}, 8'h00);
    for (i = 0; i < 2048; i++) exp_v[i] = exp_nv[i];
    chk(store_mode, 8'h00);
    rdchk(11'h7E0, 20);
    $display("test copy done");
    complete_run();
  end
endmodule : sdt_cmd_tb_top
